// ---- mpe_params.svh ----
`ifndef MPE_PARAMS_SVH
`define MPE_PARAMS_SVH
// Address that every engine accepts
`define MPE_BCAST_ADDR 8'hFF
// Packet type codes
`define MPE_T_UNSOL 8'h00
`define MPE_T_BCAST 8'h01
`define MPE_T_RESET 8'h10
`define MPE_T_BREQ 8'h24
`define MPE_T_BGNT 8'h35
`define MPE_T_DATA 8'h3F
// Data packet payload limits
`define MPE_DATA_BYTES 28
`define MPE_DATA_WORDS 14
// Duty cycle unit and clock period, both in ns
`define MPE_US_NS 1000
`define MPE_CLK_NS 20
// Least time rounds up to whole cycles
`define MPE_CYC_PER_US ((`MPE_US_NS + `MPE_CLK_NS - 1) / `MPE_CLK_NS)
`define MPE_FIFO_DEPTH 8
`endif

// ---- mpe_pkg.sv ----
`default_nettype none
`include "mpe_params.svh"
package mpe_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_HDR, TX_TYPE, TX_W2, TX_W3, TX_DATA} mpe_tx_state_t;
	typedef enum logic [2:0] {RX_HDR, RX_TYPE, RX_BODY, RX_SKIP, RX_ACT, RX_WR} mpe_rx_state_t;
	typedef struct packed {
		logic        err;
		logic        last;
		logic [15:0] data;
	} mpe_flit_t;

	// Request and grant carry length and tag words
	function automatic logic mpe_long(input logic [7:0] t);
		mpe_long = (t == `MPE_T_BREQ) || (t == `MPE_T_BGNT);
	endfunction

	function automatic logic [7:0] mpe_dest(input logic [7:0] t, input logic [7:0] d);
		mpe_dest = (t == `MPE_T_BCAST) ? `MPE_BCAST_ADDR : d;
	endfunction

	function automatic logic mpe_hit(input logic [7:0] d, input logic [7:0] me);
		mpe_hit = (d == me) || (d == `MPE_BCAST_ADDR);
	endfunction

	// Closing word of every packet except data
	function automatic logic mpe_last(input mpe_tx_state_t s, input logic [7:0] t);
		mpe_last = (s == TX_TYPE && t == `MPE_T_RESET) || (s == TX_W2 && !mpe_long(t)) || s == TX_W3;
	endfunction
endpackage
`default_nettype wire

// ---- mpe_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mpe_link_if;
	logic [15:0] a2b_data;
	logic        a2b_last;
	logic        a2b_err;
	logic        a2b_valid;
	logic        a2b_ready;
	logic [15:0] b2a_data;
	logic        b2a_last;
	logic        b2a_err;
	logic        b2a_valid;
	logic        b2a_ready;

	modport engine (output a2b_data, a2b_last, a2b_err, a2b_valid, input a2b_ready,
		input b2a_data, b2a_last, b2a_err, b2a_valid, output b2a_ready);
	modport peer (input a2b_data, a2b_last, a2b_err, a2b_valid, output a2b_ready,
		output b2a_data, b2a_last, b2a_err, b2a_valid, input b2a_ready);
endinterface
`default_nettype wire

// ---- mpe_engine.sv ----
// Operation
// - accept only own or broadcast destination
// - buffer, check, then notify host
// - host message becomes packet unchanged
// - keep pointer, send length and source tag
// - host grants no more than requested
// - host grant gives pointer, length, tag, duty
// - keep pointer, send grant with receive tag
// - matching grant stored, not passed to host
// - transfer starts without host help
// - data packets read buffer, 28 bytes max
// - pace data packets by duty value
// - clean data packets written to buffer
// - completion after last packet or error
// - clear state, report completion status
// - codes unsolicited 00, broadcast 01, reset 10
// - codes request 24, grant 35, data 3F
// - header holds source high, destination low
// - data header holds receive tag, type
// - duty counts microseconds between data packets
// - reset packet resets host, never delivered
`timescale 1ns/1ps
`default_nettype none
`include "mpe_params.svh"

module mpe_fifo #(
	parameter int W = 18,
	parameter int D = 8
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0]   cnt;
	wire           wr = in_valid && in_ready;
	wire           rd = out_valid && out_ready;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready  = cnt != (AW + 1)'(D);
	assign out_valid = cnt != '0;
	assign out_data  = mem[rptr];

	// Pointers and fill level
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wptr <= '0;
			rptr <= '0;
			cnt  <= '0;
		end else begin
			if (wr) wptr <= step(wptr);
			if (rd) rptr <= step(rptr);
			cnt <= cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
		end
	end

	// Storage needs no reset
	always_ff @(posedge clock) begin
		if (wr) mem[wptr] <= in_data;
	end
endmodule

module mpe_engine import mpe_pkg::*; #(
	parameter int DEPTH = `MPE_FIFO_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  my_addr,
	mpe_link_if.engine       lk,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_type,
	input  wire logic [7:0]  cmd_dst,
	input  wire logic [15:0] cmd_word,
	input  wire logic [15:0] cmd_ptr,
	input  wire logic [15:0] cmd_len,
	input  wire logic        gnt_valid,
	output logic             gnt_ready,
	input  wire logic [7:0]  gnt_dst,
	input  wire logic [15:0] gnt_ptr,
	input  wire logic [15:0] gnt_len,
	input  wire logic [7:0]  gnt_stag,
	input  wire logic [7:0]  gnt_duty,
	output logic             msg_valid,
	output logic [7:0]       msg_type,
	output logic [7:0]       msg_src,
	output logic [15:0]      msg_w2,
	output logic [15:0]      msg_w3,
	output logic             host_reset,
	output logic [15:0]      memr_addr,
	input  wire logic [15:0] memr_data,
	output logic             memw_en,
	output logic [15:0]      memw_addr,
	output logic [15:0]      memw_data,
	output logic             tx_done,
	output logic             rx_done,
	output logic             rx_err
);
	mpe_tx_state_t tx_st, next_tx_st;
	mpe_rx_state_t rx_st, next_rx_st;
	logic [7:0]    tx_type, tx_dst, tx_hi;
	logic [15:0]   tx_w2, tx_w3;
	logic [3:0]    tx_idx, tx_nw;
	logic          s_busy, s_granted;
	logic [7:0]    s_stag, s_rtag, s_duty, s_dst;
	logic [15:0]   s_ptr, s_rem, gap;
	logic          r_active, g_pend;
	logic [7:0]    r_rtag, r_src, g_stag, g_duty;
	logic [15:0]   r_ptr, r_rem;
	logic [7:0]    rx_src, rx_type, rx_hi;
	logic [15:0]   rx_w2, rx_w3;
	logic [3:0]    rx_n, wr_idx;
	logic          rx_bad;
	logic [15:0]   pkt_buf [`MPE_DATA_WORDS];
	mpe_flit_t     f;
	logic          f_valid;

	function automatic logic [15:0] chunk(input logic [15:0] rem);
		chunk = (rem > 16'(`MPE_DATA_BYTES)) ? 16'(`MPE_DATA_BYTES) : rem;
	endfunction

	// Transmit arbitration: grant reply, then paced data, then host command
	wire go_gnt  = tx_st == TX_IDLE && g_pend;
	wire go_data = tx_st == TX_IDLE && !g_pend && s_granted && s_rem != 16'h0000 && gap == 16'h0000;
	wire go_cmd  = tx_st == TX_IDLE && !g_pend && !go_data && cmd_valid
		&& !(cmd_type == `MPE_T_BREQ && s_busy);
	wire tx_last  = mpe_last(tx_st, tx_type) || (tx_st == TX_DATA && tx_idx == tx_nw - 4'h1);
	wire tx_adv   = lk.a2b_valid && lk.a2b_ready;
	wire data_end = tx_adv && tx_last && tx_st == TX_DATA;
	wire gnt_sent = tx_adv && tx_last && tx_type == `MPE_T_BGNT;
	wire s_final  = s_rem == chunk(s_rem);

	assign cmd_ready     = go_cmd;
	assign gnt_ready     = !g_pend && !r_active;
	assign lk.a2b_valid  = tx_st != TX_IDLE;
	assign lk.a2b_last   = tx_last;
	assign lk.a2b_err    = 1'b0;
	assign memr_addr     = s_ptr + {11'h000, tx_idx, 1'b0};
	// Word lanes per packet stage
	assign lk.a2b_data = (tx_st == TX_HDR) ? {my_addr, tx_dst} :
		(tx_st == TX_TYPE) ? {tx_hi, tx_type} :
		(tx_st == TX_W2) ? tx_w2 :
		(tx_st == TX_W3) ? tx_w3 :
		(tx_st == TX_DATA) ? memr_data : 16'h0000;

	// Transmit sequencer
	always_comb begin
		next_tx_st = tx_st;
		case (tx_st)
			TX_IDLE: if (go_gnt || go_data || go_cmd) next_tx_st = TX_HDR;
			TX_HDR: if (tx_adv) next_tx_st = TX_TYPE;
			TX_TYPE: if (tx_adv) next_tx_st = tx_last ? TX_IDLE : (tx_type == `MPE_T_DATA ? TX_DATA : TX_W2);
			TX_W2: if (tx_adv) next_tx_st = tx_last ? TX_IDLE : TX_W3;
			TX_W3: if (tx_adv) next_tx_st = TX_IDLE;
			TX_DATA: if (tx_adv && tx_last) next_tx_st = TX_IDLE;
			default: next_tx_st = TX_IDLE;
		endcase
	end

	// Packet contents latched when a packet is chosen
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_st <= TX_IDLE;
			{tx_type, tx_dst, tx_hi, tx_w2, tx_w3, tx_idx, tx_nw} <= '0;
		end else begin
			tx_st <= next_tx_st;
			if (go_gnt) begin
				tx_type <= `MPE_T_BGNT;
				tx_dst  <= r_src;
				tx_hi   <= r_rtag;
				tx_w2   <= r_rem;
				tx_w3   <= {g_duty, g_stag};
			end else if (go_data) begin
				tx_type <= `MPE_T_DATA;
				tx_dst  <= s_dst;
				tx_hi   <= s_rtag;
				tx_nw   <= 4'((chunk(s_rem) + 16'h0001) >> 1);
			end else if (go_cmd) begin
				tx_type <= cmd_type;
				tx_dst  <= mpe_dest(cmd_type, cmd_dst);
				tx_hi   <= 8'h00;
				tx_w2   <= (cmd_type == `MPE_T_BREQ) ? cmd_len : cmd_word;
				tx_w3   <= {8'h00, s_stag + 8'h01};
			end
			if (tx_st == TX_IDLE) tx_idx <= 4'h0;
			else if (tx_adv && tx_st == TX_DATA) tx_idx <= tx_idx + 4'h1;
		end
	end

	wire rx_pop_ok = rx_st == RX_HDR || rx_st == RX_TYPE || rx_st == RX_BODY || rx_st == RX_SKIP;
	// Receive path: buffered, back-pressure reaches the link
	mpe_fifo #(.W($bits(mpe_flit_t)), .D(DEPTH)) u_rxq (
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (lk.b2a_valid),
		.in_ready  (lk.b2a_ready),
		.in_data   ({lk.b2a_err, lk.b2a_last, lk.b2a_data}),
		.out_valid (f_valid),
		.out_ready (rx_pop_ok),
		.out_data  (f)
	);
	wire pop       = f_valid && rx_pop_ok;

	// Decisions taken once a whole packet is held and checked
	wire       act     = rx_st == RX_ACT;
	wire       ok      = !rx_bad;
	wire       is_sys  = rx_type == `MPE_T_RESET || rx_type == `MPE_T_BGNT || rx_type == `MPE_T_DATA;
	wire       ev_msg  = act && ok && !is_sys;
	wire       ev_rst  = act && ok && rx_type == `MPE_T_RESET;
	wire       ev_gnt  = act && ok && rx_type == `MPE_T_BGNT && s_busy && !s_granted
		&& rx_w3[7:0] == s_stag && rx_src == s_dst;
	wire       dat     = act && rx_type == `MPE_T_DATA && r_active && !g_pend;
	wire [15:0] nbytes = {11'h000, rx_n, 1'b0};
	wire       over    = nbytes > r_rem + 16'h0001;
	wire       tag_ok  = rx_hi == r_rtag && rx_src == r_src;
	wire       ev_wr   = dat && ok && tag_ok && !over && rx_n != 4'h0;
	wire       ev_fail = dat && (!ok || !tag_ok || over);
	wire       wr_last = rx_st == RX_WR && wr_idx == rx_n - 4'h1;
	wire [15:0] applied = (nbytes > r_rem) ? r_rem : nbytes;

	assign memw_en   = rx_st == RX_WR;
	assign memw_addr = r_ptr + {11'h000, wr_idx, 1'b0};
	assign memw_data = pkt_buf[wr_idx];

	// Receive sequencer
	always_comb begin
		next_rx_st = rx_st;
		case (rx_st)
			RX_HDR: if (pop && !f.last) next_rx_st = mpe_hit(f.data[7:0], my_addr) ? RX_TYPE : RX_SKIP;
			RX_TYPE: if (pop) next_rx_st = f.last ? RX_ACT : RX_BODY;
			RX_BODY: if (pop && f.last) next_rx_st = RX_ACT;
			RX_SKIP: if (pop && f.last) next_rx_st = RX_HDR;
			RX_ACT: next_rx_st = ev_wr ? RX_WR : RX_HDR;
			RX_WR: if (wr_last) next_rx_st = RX_HDR;
			default: next_rx_st = RX_HDR;
		endcase
	end

	// Header fields and error summary of the packet in hand
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rx_st <= RX_HDR;
			{rx_src, rx_type, rx_hi, rx_w2, rx_w3, rx_n, rx_bad, wr_idx} <= '0;
		end else begin
			rx_st <= next_rx_st;
			if (pop && rx_st == RX_HDR) begin
				rx_src <= f.data[15:8];
				rx_bad <= f.err;
				rx_n   <= 4'h0;
			end else if (pop && rx_st == RX_TYPE) begin
				{rx_hi, rx_type} <= f.data;
				rx_bad <= rx_bad | f.err;
			end else if (pop && rx_st == RX_BODY) begin
				if (rx_n == 4'h0) rx_w2 <= f.data;
				if (rx_n == 4'h1) rx_w3 <= f.data;
				if (rx_n != 4'(`MPE_DATA_WORDS)) rx_n <= rx_n + 4'h1;
				rx_bad <= rx_bad | f.err | (rx_n == 4'(`MPE_DATA_WORDS)); // Longer than a packet may be
			end
			wr_idx <= (rx_st == RX_WR) ? wr_idx + 4'h1 : 4'h0;
		end
	end

	// Payload held until the packet proves clean
	always_ff @(posedge clock) begin
		if (pop && rx_st == RX_BODY && rx_n != 4'(`MPE_DATA_WORDS)) pkt_buf[rx_n] <= f.data;
	end

	// Sending side of a block transfer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{s_busy, s_granted, s_stag, s_rtag, s_duty, s_dst, s_ptr, s_rem, gap} <= '0;
		end else begin
			if (go_cmd && cmd_type == `MPE_T_BREQ) begin
				s_busy <= 1'b1;
				s_ptr  <= cmd_ptr;
				s_dst  <= cmd_dst;
				s_stag <= s_stag + 8'h01;
			end
			if (ev_gnt) begin
				s_granted <= rx_w2 != 16'h0000;
				s_busy    <= rx_w2 != 16'h0000;
				s_rem     <= rx_w2;
				s_rtag    <= rx_hi;
				s_duty    <= rx_w3[15:8];
			end
			if (data_end) begin
				s_ptr <= s_ptr + {11'h000, tx_nw, 1'b0};
				s_rem <= s_rem - chunk(s_rem);
				if (s_final) {s_busy, s_granted} <= 2'b00;
			end
			if (data_end) gap <= 16'(s_duty) * 16'(`MPE_CYC_PER_US);
			else if (gap != 16'h0000) gap <= gap - 16'h0001;
		end
	end

	// Receiving side of a block transfer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{r_active, g_pend, r_rtag, r_src, g_stag, g_duty, r_ptr, r_rem} <= '0;
		end else begin
			if (gnt_valid && gnt_ready) begin
				r_active <= 1'b1;
				g_pend   <= 1'b1;
				r_ptr    <= gnt_ptr;
				r_rem    <= gnt_len;
				r_src    <= gnt_dst;
				r_rtag   <= r_rtag + 8'h01;
				g_stag   <= gnt_stag;
				g_duty   <= gnt_duty;
			end
			if (gnt_sent) begin
				g_pend <= 1'b0;
				if (r_rem == 16'h0000) r_active <= 1'b0;
			end
			if (wr_last) begin
				r_ptr <= r_ptr + nbytes;
				r_rem <= r_rem - applied;
				if (r_rem == applied) r_active <= 1'b0;
			end
			if (ev_fail) r_active <= 1'b0;
		end
	end

	// Host notifications, one-cycle pulses
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{msg_valid, msg_type, msg_src, msg_w2, msg_w3, host_reset, tx_done, rx_done, rx_err} <= '0;
		end else begin
			msg_valid  <= ev_msg;
			host_reset <= ev_rst;
			if (ev_msg) {msg_type, msg_src, msg_w2, msg_w3} <= {rx_type, rx_src, rx_w2, rx_w3};
			tx_done <= (ev_gnt && rx_w2 == 16'h0000) || (data_end && s_final);
			rx_done <= (gnt_sent && r_rem == 16'h0000) || (wr_last && r_rem == applied) || ev_fail;
			rx_err  <= ev_fail;
		end
	end
endmodule
`default_nettype wire

// ---- mpe_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpe_params.svh"

module mpe_peer import mpe_pkg::*; (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  my_addr,
	mpe_link_if.peer         lk,
	input  wire logic [15:0] cap_len,
	input  wire logic [7:0]  duty,
	input  wire logic        corrupt,
	input  wire logic        send_valid,
	output logic             send_ready,
	input  wire logic [7:0]  send_type,
	input  wire logic [7:0]  send_dst,
	input  wire logic [7:0]  send_hi,
	input  wire logic [15:0] send_word,
	output logic             rx_valid,
	output logic [15:0]      rx_word,
	output logic [7:0]       rx_type,
	output logic [7:0]       rx_src,
	output logic             rx_end,
	output logic             rx_bad
);
	mpe_tx_state_t pt_st, next_pt_st;
	mpe_rx_state_t pr_st;
	logic [7:0]    pt_type, pt_dst, pt_hi;
	logic [15:0]   pt_w2, pt_w3, pr_w2;
	logic          pt_bad, pr_bad, pg_pend;
	logic [7:0]    pr_hi, pg_dst, pg_stag, p_rtag;
	logic [15:0]   pg_len;
	logic [1:0]    pr_n;

	wire go_g    = pt_st == TX_IDLE && pg_pend;
	wire go_u    = pt_st == TX_IDLE && !pg_pend && send_valid;
	wire pt_last = mpe_last(pt_st, pt_type);
	wire pt_adv  = lk.b2a_valid && lk.b2a_ready;
	wire pop     = lk.a2b_valid;
	wire bad_now = pr_bad | lk.a2b_err;
	// A clean request closing now earns a grant
	wire req_end = pop && lk.a2b_last && pr_st == RX_BODY && rx_type == `MPE_T_BREQ && !bad_now && !pg_pend;

	assign send_ready   = go_u;
	assign lk.a2b_ready = 1'b1;
	assign lk.b2a_valid = pt_st != TX_IDLE;
	assign lk.b2a_last  = pt_last;
	assign lk.b2a_err   = pt_bad && pt_last;
	assign lk.b2a_data  = (pt_st == TX_HDR) ? {my_addr, pt_dst} :
		(pt_st == TX_TYPE) ? {pt_hi, pt_type} :
		(pt_st == TX_W2) ? pt_w2 : pt_w3;

	// Transmit sequencer; a data packet here carries one word
	always_comb begin
		next_pt_st = pt_st;
		case (pt_st)
			TX_IDLE: if (go_g || go_u) next_pt_st = TX_HDR;
			TX_HDR: if (pt_adv) next_pt_st = TX_TYPE;
			TX_TYPE: if (pt_adv) next_pt_st = pt_last ? TX_IDLE : TX_W2;
			TX_W2: if (pt_adv) next_pt_st = pt_last ? TX_IDLE : TX_W3;
			default: if (pt_adv) next_pt_st = TX_IDLE;
		endcase
	end

	// Packet contents latched when a packet is chosen
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pt_st <= TX_IDLE;
			{pt_type, pt_dst, pt_hi, pt_w2, pt_w3, pt_bad} <= '0;
		end else begin
			pt_st <= next_pt_st;
			if (go_g) begin
				pt_type <= `MPE_T_BGNT;
				pt_dst  <= pg_dst;
				pt_hi   <= p_rtag;
				pt_w2   <= pg_len;
				pt_w3   <= {duty, pg_stag};
				pt_bad  <= 1'b0;
			end else if (go_u) begin
				pt_type <= send_type;
				pt_dst  <= mpe_dest(send_type, send_dst);
				pt_hi   <= (send_type == `MPE_T_DATA) ? send_hi : 8'h00;
				pt_w2   <= send_word;
				pt_w3   <= {8'h00, send_hi};
				pt_bad  <= corrupt;
			end
		end
	end

	// Receive parser; the link is never stalled here
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pr_st <= RX_HDR;
			{pr_bad, pr_hi, pr_w2, pr_n, rx_valid, rx_word, rx_type, rx_src, rx_end, rx_bad} <= '0;
		end else begin
			rx_valid <= pop && pr_st == RX_BODY;
			rx_end   <= pop && lk.a2b_last && (pr_st == RX_TYPE || pr_st == RX_BODY);
			if (pop) begin
				case (pr_st)
					RX_HDR: begin
						rx_src <= lk.a2b_data[15:8];
						pr_bad <= lk.a2b_err;
						pr_n   <= 2'h0;
						if (!lk.a2b_last) pr_st <= mpe_hit(lk.a2b_data[7:0], my_addr) ? RX_TYPE : RX_SKIP;
					end
					RX_TYPE: begin
						{pr_hi, rx_type} <= lk.a2b_data;
						pr_bad <= bad_now;
						rx_bad <= bad_now;
						pr_st  <= lk.a2b_last ? RX_HDR : RX_BODY;
					end
					RX_BODY: begin
						rx_word <= lk.a2b_data;
						pr_bad  <= bad_now;
						rx_bad  <= bad_now;
						if (pr_n == 2'h0) pr_w2 <= lk.a2b_data;
						if (pr_n != 2'h3) pr_n <= pr_n + 2'h1;
						if (lk.a2b_last) pr_st <= RX_HDR;
					end
					default: if (lk.a2b_last) pr_st <= RX_HDR;
				endcase
			end
		end
	end

	// Grant reply state; granted length never above the request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{pg_pend, pg_dst, pg_stag, pg_len, p_rtag} <= '0;
		end else begin
			if (req_end) begin
				pg_pend <= 1'b1;
				pg_dst  <= rx_src;
				pg_stag <= lk.a2b_data[7:0];
				pg_len  <= (pr_w2 < cap_len) ? pr_w2 : cap_len;
				p_rtag  <= p_rtag + 8'h01;
			end else if (go_g) begin
				pg_pend <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- mpe_link_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpe_params.svh"
module mpe_link_props #(
	parameter logic [7:0] A_ADDR = 8'h12,
	parameter logic [7:0] B_ADDR = 8'h34,
	parameter int         DUTY   = 2
) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [15:0] a2b_data,
	input wire logic        a2b_last,
	input wire logic        a2b_err,
	input wire logic        a2b_valid,
	input wire logic        a2b_ready,
	input wire logic [15:0] b2a_data,
	input wire logic        b2a_last,
	input wire logic        b2a_err,
	input wire logic        b2a_valid,
	input wire logic        b2a_ready
);
	localparam int MIN_GAP = DUTY * `MPE_CYC_PER_US + 1;
	logic [3:0]      ai, bi;
	logic [7:0]      at, bt, bd;
	logic [15:0]     gap;
	wire logic       a_go = a2b_valid && a2b_ready;
	wire logic       b_go = b2a_valid && b2a_ready;
	wire logic [7:0] a_ty = (ai == 4'h1) ? a2b_data[7:0] : at;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Word position per direction; gap is set to its maximum at a request so the first packet is free
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{ai, bi, at, bt, bd} <= '0;
			gap <= 16'hFFFF;
		end else begin
			if (a_go) ai <= a2b_last ? 4'h0 : ai + 4'h1;
			if (a_go && ai == 4'h1) at <= a2b_data[7:0];
			if (b_go) bi <= b2a_last ? 4'h0 : bi + 4'h1;
			if (b_go && bi == 4'h1) bt <= b2a_data[7:0];
			if (b_go && bi == 4'h0) bd <= b2a_data[7:0];
			if (a_go && a2b_last && a_ty == 8'h3F) gap <= 16'h0000;
			else if (a_go && ai == 4'h1 && a2b_data[7:0] == 8'h24) gap <= 16'hFFFF;
			else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
		end
	end
	property p_srca; a_go && ai == 4'h0 |-> a2b_data[15:8] == A_ADDR; endproperty
	a_srca: assert property (p_srca) else $error("bad source a");
	property p_srcb; b_go && bi == 4'h0 |-> b2a_data[15:8] == B_ADDR; endproperty
	a_srcb: assert property (p_srcb) else $error("bad source b");
	property p_bcast; b_go && bi == 4'h1 && b2a_data[7:0] == 8'h01 |-> bd == 8'hFF; endproperty
	a_bcast: assert property (p_bcast) else $error("bad broadcast dest");
	property p_rst; b_go && bi == 4'h1 && b2a_data[7:0] == 8'h10 |-> b2a_last; endproperty
	a_rst: assert property (p_rst) else $error("reset packet too long");
	property p_long; a_go && ai == 4'h3 && (at == 8'h24 || at == 8'h35) |-> a2b_last; endproperty
	a_long: assert property (p_long) else $error("bad request length");
	property p_gduty; b_go && bi == 4'h3 && bt == 8'h35 |-> b2a_data[15:8] == DUTY[7:0]; endproperty
	a_gduty: assert property (p_gduty) else $error("bad grant duty");
	property p_dmax; a_go && ai == 4'hF && at == 8'h3F |-> a2b_last; endproperty
	a_dmax: assert property (p_dmax) else $error("data packet too long");
	property p_gap; a_go && ai == 4'h1 && a2b_data[7:0] == 8'h3F |-> gap >= MIN_GAP; endproperty
	a_gap: assert property (p_gap) else $error("data packets too close");
	c_data: cover property (a_go && a2b_last && a_ty == 8'h3F);
	c_grant: cover property (b_go && bi == 4'h1 && b2a_data[7:0] == 8'h35);
	c_rst: cover property (b_go && bi == 4'h1 && b2a_data[7:0] == 8'h10);
endmodule
`default_nettype wire

// ---- message_passing_packet_engine_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module message_passing_packet_engine_tb_top;
	logic        clock = 0, resetn = 0, cmd_valid, cmd_ready, gnt_valid, gnt_ready, msg_valid, host_reset;
	logic        memw_en, tx_done, rx_done, rx_err, corrupt, send_valid, send_ready, got_err;
	logic        rx_valid, rx_end, rx_bad;
	logic [7:0]  cmd_type, cmd_dst, gnt_dst, gnt_stag, gnt_duty, msg_type, msg_src;
	logic [7:0]  duty, send_type, send_dst, send_hi, rx_type, rx_src, t8, d8;
	logic [15:0] cmd_word, cmd_ptr, cmd_len, gnt_ptr, gnt_len, msg_w2, msg_w3, memr_addr, w16;
	logic [15:0] memr_data, memw_addr, memw_data, cap_len, send_word, rx_word;
	logic [15:0] base, wa [4], wd [4];
	logic [31:0] pw, rq, gq;
	logic [2:0]  fl;
	int          err_count, num_checks, n_msg, n_rst, n_tx, n_rxd, n_dat, n_wr, cyc;
	logic [7:0]  ety [3] = '{8'h00, 8'h01, 8'h10};
	// Peer to engine: type, dest, word, {corrupt, message, host reset}
	logic [34:0] rows [5] = '{{8'h00, 8'h12, 16'h1234, 3'b010}, {8'h01, 8'h55, 16'hABCD, 3'b010},
		{8'h10, 8'h12, 16'h0000, 3'b001}, {8'h00, 8'h33, 16'h5555, 3'b000}, {8'h00, 8'h12, 16'h6666, 3'b100}};

	mpe_link_if lk ();
	mpe_engine i_mpe_engine (.*, .my_addr(8'h12), .lk(lk));
	mpe_peer i_mpe_peer (.*, .my_addr(8'h34), .lk(lk));
	mpe_link_props #(.A_ADDR(8'h12), .B_ADDR(8'h34), .DUTY(2)) i_mpe_link_props (.clock, .resetn,
		.a2b_data(lk.a2b_data), .a2b_last(lk.a2b_last), .a2b_err(lk.a2b_err), .a2b_valid(lk.a2b_valid),
		.a2b_ready(lk.a2b_ready), .b2a_data(lk.b2a_data), .b2a_last(lk.b2a_last), .b2a_err(lk.b2a_err),
		.b2a_valid(lk.b2a_valid), .b2a_ready(lk.b2a_ready));

	// Host memory answers in the same cycle, each low address byte its own pattern
	function automatic logic [15:0] memv(input logic [15:0] a);
		return {a[7:0] ^ 8'hA5, a[7:0]};
	endfunction
	assign memr_data = memv(memr_addr);

	always #10 clock = ~clock;

	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic clr;
		{n_msg, n_rst, n_tx, n_rxd, n_dat, n_wr} = '0;
	endtask
	// Each request holds until the edge that sees ready, then settles 40 cycles
	task automatic psend(input logic [7:0] t, d, h, input logic [15:0] w, input logic c);
		{send_type, send_dst, send_hi, send_word, corrupt} = {t, d, h, w, c};
		send_valid = 1'b1;
		do @(posedge clock); while (send_ready !== 1'b1);
		#1;
		send_valid = 1'b0;
		repeat (40) tick();
	endtask
	task automatic hsend(input logic [7:0] t, input logic [15:0] w, p, l);
		{cmd_type, cmd_dst, cmd_word, cmd_ptr, cmd_len} = {t, 8'h34, w, p, l};
		cmd_valid = 1'b1;
		do @(posedge clock); while (cmd_ready !== 1'b1);
		#1;
		cmd_valid = 1'b0;
		repeat (40) tick();
	endtask
	task automatic gsend(input logic [15:0] p, l, input logic [7:0] s);
		{gnt_dst, gnt_ptr, gnt_len, gnt_stag} = {8'h34, p, l, s};
		gnt_valid = 1'b1;
		do @(posedge clock); while (gnt_ready !== 1'b1);
		#1;
		gnt_valid = 1'b0;
		repeat (40) tick();
	endtask

	// Event capture; also cuts a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
		if (msg_valid === 1'b1) n_msg++;
		if (host_reset === 1'b1) n_rst++;
		if (tx_done === 1'b1) n_tx++;
		if (rx_done === 1'b1) begin
			n_rxd++;
			got_err = rx_err;
		end
		if (memw_en === 1'b1) begin
			if (n_wr < 4) {wa[n_wr], wd[n_wr]} = {memw_addr, memw_data};
			n_wr++;
		end
		if (rx_valid === 1'b1) pw = {pw[15:0], rx_word};
		if (rx_end === 1'b1) check(rx_bad, 1'b0);
		if (rx_valid === 1'b1 && rx_type === 8'h3F) begin
			check(rx_word, memv(base + 16'(2 * n_dat)));
			n_dat++;
		end
		if (rx_end === 1'b1 && rx_type === 8'h24) rq = pw;
		if (rx_end === 1'b1 && rx_type === 8'h35) gq = pw;
	end

	initial begin
		{cmd_valid, gnt_valid, send_valid, corrupt} = '0;
		{cmd_type, cmd_dst, cmd_word, cmd_ptr, cmd_len, gnt_dst, gnt_ptr, gnt_len, gnt_stag} = '0;
		{send_type, send_dst, send_hi, send_word} = '0;
		{gnt_duty, duty, cap_len} = {8'h02, 8'h02, 16'd40};
		repeat (3) @(posedge clock);
		#1;
		check(gnt_ready, 1'b1);
		check(lk.b2a_ready, 1'b1);
		resetn = 1'b1;
		$display("reset done");
		foreach (rows[i]) begin
			{t8, d8, w16, fl} = rows[i];
			clr();
			psend(t8, d8, 8'h00, w16, fl[2]);
			check(n_msg, fl[1]);
			check(n_rst, fl[0]);
			check({lk.b2a_ready, i_mpe_engine.f_valid}, 2'b10);
			if (fl[1]) check({msg_type, msg_src, msg_w2}, {t8, 8'h34, w16});
			$display("row %0d done", i);
		end
		foreach (ety[i]) begin
			hsend(ety[i], 16'hBEEF, 16'h0, 16'h0);
			check({rx_type, rx_src, pw[15:0]}, {ety[i], 8'h12, 16'hBEEF});
		end
		$display("send types done");
		// Block send, granted less than asked, two packets gap paced
		clr();
		base = 16'h0100;
		hsend(8'h24, 16'h0, base, 16'd60);
		for (int k = 0; k < 3000 && n_tx == 0; k++) tick();
		check(rq, {16'd60, 16'h0001});
		check(n_dat, 20);
		check(n_tx, 1);
		check(n_msg, 0);
		check({lk.b2a_ready, i_mpe_engine.f_valid}, 2'b10);
		$display("block send done");
		// Block receive, two one-word packets
		clr();
		psend(8'h24, 8'h12, 8'h07, 16'd4, 1'b0);
		check({msg_type, msg_w2, msg_w3}, {8'h24, 16'd4, 16'h0007});
		gsend(16'h0200, 16'd4, 8'h07);
		check(gq, {16'd4, 16'h0207});
		psend(8'h3F, 8'h12, 8'h01, 16'hA1A2, 1'b0);
		psend(8'h3F, 8'h12, 8'h01, 16'hB1B2, 1'b0);
		check({wa[0], wd[0]}, {16'h0200, 16'hA1A2});
		check({wa[1], wd[1]}, {16'h0202, 16'hB1B2});
		check({8'(n_rxd), got_err}, {8'd1, 1'b0});
		// Wrong receive tag ends the transfer with an error
		clr();
		psend(8'h24, 8'h12, 8'h08, 16'd4, 1'b0);
		gsend(16'h0300, 16'd4, 8'h08);
		psend(8'h3F, 8'h12, 8'h09, 16'hC1C2, 1'b0);
		check({8'(n_wr), 8'(n_rxd), got_err}, {8'd0, 8'd1, 1'b1});
		check({lk.b2a_ready, i_mpe_engine.f_valid}, 2'b10);
		$display("block receive done");
		wrap_up();
	end
endmodule
`default_nettype wire
